// File: hw/tim_input_meas.sv
// Timer channel in input measurement modes with an AXI4-Lite register slave
`include "tim_defines.svh"
`default_nettype none

// Notes on behaviour
// [R1] Rising-period mode captures 32-bit tick count between successive rising edges.
// [R2] Period result refreshes on every qualifying edge; reads give latest interval.
// [R3] Falling-period mode is identical but uses falling edges.
// [R4] Writing zero to the value word resets it; reads give zero until an edge, except in duty mode (see R8).
// [R5] A read paired with a reset returns the value held just before it.
// [R6] Duty mode returns high ticks in low half, low ticks in high half.
// [R7] Low word updates at high-phase end, high word at low-phase end.
// [R8] Duty reset loads 0/65535 if input low, 65535/0 if high.
// [R9] Counter mode adds one per rising edge into a 32-bit count.
// [R10] Debounce length is setting low byte times 16 ms, plus up to 16 ms.
// [R11] Setting bit 8 picks positive edges when set, negative when clear.
// [R12] Debounced counter adds one, ignores edges until debounce ends, re-arms.
// [R13] Period and duty ticks use the shared divided timer clock.
// [R14] Software should keep timer clock under 65535 times signal frequency.
// [R15] Debounced mode suits signals slower than 10 Hz.
// [R16] Divider field 0-255; zero divides by 256, else by its value.
// [R17] Duty high and low counters saturate at 65535 instead of wrapping.
module tim_input_meas (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // Measured pin
  input wire logic MEAS_PIN_IN,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [3:0] S_AXI_AWADDR_IN,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  // AXI4-Lite write response
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  output logic [1:0] S_AXI_BRESP_OUT,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  input wire logic [3:0] S_AXI_ARADDR_IN,
  // AXI4-Lite read data
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT
);
  //--------------------------------------------------------------------
  // Declarations
  //--------------------------------------------------------------------
  logic aw_ff, nxt_aw, w_ff, nxt_w, bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid, tick_ff, nxt_tick, pin_d_ff, nxt_pin_d;
  logic [3:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [2:0] mode_ff, nxt_mode, timer_base_select_ff, nxt_timer_base_select;
  logic [7:0] timer_clock_divider_ff, nxt_timer_clock_divider, div_cnt_ff, nxt_div_cnt;
  logic [15:0] channel_setting_word_ff, nxt_channel_setting_word;
  logic [5:0] pre_cnt_ff, nxt_pre_cnt;
  logic [31:0] per_acc_ff, nxt_per_acc, per_now, value_ff, nxt_value;
  logic [15:0] phase_acc_ff, nxt_phase_acc, phase_now;
  tim_pkg::tim_deb_state_type deb_st_ff, nxt_deb_st;
  logic [19:0] deb_tick_ff, nxt_deb_tick;
  logic [8:0] deb_left_ff, nxt_deb_left;
  logic wr_go, value_wr, value_clr, rise, fall;
  // Saturating 16-bit increment shared by duty phase counter paths
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == `TIM_SAT16) ? v : v + 16'h0001;
  endfunction
  // Prescale count per base selection; fixed bases ignore the divider
  function automatic logic [5:0] pre_limit(input logic [2:0] sel);
    case (sel[1:0])
      2'h0: pre_limit = 6'(`TIM_BASE_PRE0 - 1);
      2'h1: pre_limit = 6'(`TIM_BASE_PRE1 - 1);
      2'h2: pre_limit = 6'(`TIM_BASE_PRE2 - 1);
      default: pre_limit = 6'(`TIM_BASE_PRE3 - 1);
    endcase
  endfunction
  assign wr_go = aw_ff && w_ff && !bvalid_ff;
  assign value_wr = wr_go && (awaddr_ff == `TIM_OFS_VALUE);
  // [R4] zero write resets
  assign value_clr = value_wr && (wdata_ff == `TIM_ZERO32);
  assign rise = MEAS_PIN_IN && !pin_d_ff;
  assign fall = !MEAS_PIN_IN && pin_d_ff;
  // A tick in the edge cycle belongs to the interval that the edge closes, else phase skews it
  assign per_now = per_acc_ff + {31'h0, tick_ff};
  assign phase_now = tick_ff ? sat_inc(phase_acc_ff) : phase_acc_ff;
  //--------------------------------------------------------------------
  // AXI4-Lite slave
  //--------------------------------------------------------------------
  // Address and data are latched independently, so either may come first
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    nxt_mode = mode_ff;
    nxt_timer_base_select = timer_base_select_ff;
    nxt_timer_clock_divider = timer_clock_divider_ff;
    nxt_channel_setting_word = channel_setting_word_ff;
    if (S_AXI_AWVALID_IN && !aw_ff) begin
      nxt_aw = 1'b1;
      nxt_awaddr = {S_AXI_AWADDR_IN[3:2], 2'h0};
    end
    if (S_AXI_WVALID_IN && !w_ff) begin
      nxt_w = 1'b1;
      nxt_wdata = S_AXI_WDATA_IN;
    end
    if (wr_go) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `TIM_RESP_OKAY;
      case (awaddr_ff)
        `TIM_OFS_MODE: nxt_mode = wdata_ff[`TIM_MODE_MSB:`TIM_MODE_LSB];
        `TIM_OFS_CLKCFG: begin
          nxt_timer_base_select = wdata_ff[`TIM_BASE_MSB:`TIM_BASE_LSB];
          nxt_timer_clock_divider = wdata_ff[`TIM_DIV_MSB:`TIM_DIV_LSB];
        end
        `TIM_OFS_VALUE: nxt_channel_setting_word = wdata_ff[15:0];
        // Status is read-only, so it is refused along with unmapped words
        default: nxt_bresp = `TIM_RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && S_AXI_BREADY_IN) begin
      nxt_bvalid = 1'b0;
    end
    // [R5] read snapshot before reset; ready stays low while read data is pending
    if (S_AXI_ARVALID_IN && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = `TIM_RESP_OKAY;
      nxt_rdata = `TIM_ZERO32;
      case ({S_AXI_ARADDR_IN[3:2], 2'h0})
        `TIM_OFS_MODE: nxt_rdata = {29'h0, mode_ff};
        `TIM_OFS_CLKCFG: nxt_rdata = {16'h0, timer_clock_divider_ff, 5'h0, timer_base_select_ff};
        `TIM_OFS_VALUE: nxt_rdata = value_ff;
        `TIM_OFS_STATUS: nxt_rdata = {21'h0, deb_st_ff == tim_pkg::TIM_DEB_HOLD,
                                      deb_left_ff, MEAS_PIN_IN};
        default: nxt_rresp = `TIM_RESP_SLVERR;
      endcase
    end
    if (rvalid_ff && S_AXI_RREADY_IN) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
  end
  // Bus state registers
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `TIM_RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `TIM_RESP_OKAY;
      mode_ff <= `TIM_MODE_RST;
      timer_base_select_ff <= `TIM_BASE_RST;
      timer_clock_divider_ff <= `TIM_DIV_RST;
      channel_setting_word_ff <= 16'h0;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      mode_ff <= nxt_mode;
      timer_base_select_ff <= nxt_timer_base_select;
      timer_clock_divider_ff <= nxt_timer_clock_divider;
      channel_setting_word_ff <= nxt_channel_setting_word;
    end
  end
  //--------------------------------------------------------------------
  // Timer clock: base prescale then optional divider, as an enable pulse
  //--------------------------------------------------------------------
  always_comb begin
    nxt_pre_cnt = pre_cnt_ff + 6'h01;
    nxt_div_cnt = div_cnt_ff;
    nxt_tick = 1'b0;
    if (pre_cnt_ff >= pre_limit(timer_base_select_ff)) begin
      nxt_pre_cnt = 6'h00;
      if (!timer_base_select_ff[2]) begin
        nxt_tick = 1'b1;
      end else begin
        // [R16] zero divides by 256
        nxt_div_cnt = div_cnt_ff + 8'h01;
        if (div_cnt_ff + 8'h01 == timer_clock_divider_ff) begin
          nxt_div_cnt = 8'h00;
          nxt_tick = 1'b1;
        end
      end
    end
  end
  // Divider registers
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      pre_cnt_ff <= 6'h00;
      div_cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
      div_cnt_ff <= nxt_div_cnt;
      tick_ff <= nxt_tick;
    end
  end
  //--------------------------------------------------------------------
  // Measurement engine
  //--------------------------------------------------------------------
  // Value word is the only result register; mode picks how edges feed it
  always_comb begin
    nxt_pin_d = MEAS_PIN_IN;
    nxt_per_acc = per_acc_ff;
    nxt_value = value_ff;
    nxt_phase_acc = phase_acc_ff;
    nxt_deb_st = deb_st_ff;
    nxt_deb_tick = deb_tick_ff;
    nxt_deb_left = deb_left_ff;
    case (mode_ff)
      `TIM_MODE_PER_RISE, `TIM_MODE_PER_FALL: begin
        // [R13] count divided ticks
        nxt_per_acc = per_now;
        // [R1] [R2] [R3] capture on chosen edge
        if ((mode_ff == `TIM_MODE_PER_RISE) ? rise : fall) begin
          nxt_value = per_now;
          nxt_per_acc = `TIM_ZERO32;
        end
      end
      `TIM_MODE_DUTY: begin
        // [R17] saturating phase count
        nxt_phase_acc = phase_now;
        // [R6] [R7] high ticks low half, low ticks high half
        if (fall) begin
          nxt_value[`TIM_HALF_W-1:0] = phase_now;
          nxt_phase_acc = 16'h0;
        end else if (rise) begin
          nxt_value[31:`TIM_HALF_W] = phase_now;
          nxt_phase_acc = 16'h0;
        end
      end
      `TIM_MODE_CNT: begin
        // [R9] count rising edges
        if (rise) begin
          nxt_value = value_ff + 32'h1;
        end
      end
      `TIM_MODE_DEB: begin
        nxt_deb_tick = deb_tick_ff + 20'h1;
        if (deb_tick_ff == 20'(`TIM_DEB_TICK_CYC - 1)) begin
          nxt_deb_tick = 20'h0;
        end
        case (deb_st_ff)
          tim_pkg::TIM_DEB_ARMED: begin
            // [R11] [R12] count chosen edge
            if (channel_setting_word_ff[`TIM_DEB_POL_BIT] ? rise : fall) begin
              nxt_value = value_ff + 32'h1;
              nxt_deb_st = tim_pkg::TIM_DEB_HOLD;
              // [R10] low byte plus partial tick
              nxt_deb_left = {1'b0, channel_setting_word_ff[`TIM_DEB_LEN_MSB:`TIM_DEB_LEN_LSB]}
                             + 9'h1;
            end
          end
          tim_pkg::TIM_DEB_HOLD: begin
            if (deb_tick_ff == 20'(`TIM_DEB_TICK_CYC - 1)) begin
              nxt_deb_left = deb_left_ff - 9'h1;
              if (deb_left_ff == 9'h1) begin
                nxt_deb_st = tim_pkg::TIM_DEB_ARMED;
              end
            end
          end
          default: nxt_deb_st = tim_pkg::TIM_DEB_ARMED;
        endcase
      end
      default: nxt_value = value_ff;
    endcase
    // [R4] [R8] reset beats same-cycle edge
    if (value_clr) begin
      nxt_per_acc = `TIM_ZERO32;
      nxt_phase_acc = 16'h0;
      nxt_deb_st = tim_pkg::TIM_DEB_ARMED;
      nxt_deb_left = 9'h0;
      if (mode_ff == `TIM_MODE_DUTY) begin
        nxt_value = MEAS_PIN_IN ? {16'h0, `TIM_SAT16} : {`TIM_SAT16, 16'h0};
      end else begin
        nxt_value = `TIM_ZERO32;
      end
    end
  end
  // Measurement registers
  always_ff @(posedge MCLK_IN) begin
    if (SYS_RST_IN) begin
      pin_d_ff <= 1'b0;
      per_acc_ff <= `TIM_ZERO32;
      value_ff <= `TIM_ZERO32;
      phase_acc_ff <= 16'h0;
      deb_st_ff <= tim_pkg::TIM_DEB_ARMED;
      deb_tick_ff <= 20'h0;
      deb_left_ff <= 9'h0;
    end else begin
      pin_d_ff <= nxt_pin_d;
      per_acc_ff <= nxt_per_acc;
      value_ff <= nxt_value;
      phase_acc_ff <= nxt_phase_acc;
      deb_st_ff <= nxt_deb_st;
      deb_tick_ff <= nxt_deb_tick;
      deb_left_ff <= nxt_deb_left;
    end
  end
  // Outputs straight from flip-flops
  assign S_AXI_AWREADY_OUT = !aw_ff;
  assign S_AXI_WREADY_OUT = !w_ff;
  assign S_AXI_BVALID_OUT = bvalid_ff;
  assign S_AXI_BRESP_OUT = bresp_ff;
  assign S_AXI_ARREADY_OUT = arready_ff;
  assign S_AXI_RVALID_OUT = rvalid_ff;
  assign S_AXI_RDATA_OUT = rdata_ff;
  assign S_AXI_RRESP_OUT = rresp_ff;

endmodule
`default_nettype wire

// File: hw/tim_defines.svh
// Constants for the timer input measurement channel
`ifndef TIM_DEFINES_SVH
`define TIM_DEFINES_SVH

// Register byte offsets
`define TIM_OFS_MODE    4'h0
`define TIM_OFS_CLKCFG  4'h4
`define TIM_OFS_VALUE   4'h8
`define TIM_OFS_STATUS  4'hc

// Mode encodings held in the mode register
`define TIM_MODE_PER_RISE 3'h2
`define TIM_MODE_PER_FALL 3'h3
`define TIM_MODE_DUTY     3'h4
`define TIM_MODE_CNT      3'h5
`define TIM_MODE_DEB      3'h6

// Field layout
`define TIM_MODE_LSB     0
`define TIM_MODE_MSB     2
`define TIM_BASE_LSB     0
`define TIM_BASE_MSB     2
`define TIM_DIV_LSB      8
`define TIM_DIV_MSB      15
`define TIM_DEB_LEN_LSB  0
`define TIM_DEB_LEN_MSB  7
`define TIM_DEB_POL_BIT  8
`define TIM_HALF_W       16

// Reset values
`define TIM_MODE_RST   3'h2
`define TIM_BASE_RST   3'h0
`define TIM_DIV_RST    8'h01
`define TIM_SAT16      16'hffff
`define TIM_ZERO32     32'h00000000

// Timing: 50 MHz system clock, base prescales and debounce tick
`define TIM_CLK_HZ       50000000
`define TIM_DEB_TICK_MS  16
`define TIM_DEB_TICK_CYC ((`TIM_CLK_HZ / 1000) * `TIM_DEB_TICK_MS)
`define TIM_BASE_PRE0    2
`define TIM_BASE_PRE1    5
`define TIM_BASE_PRE2    10
`define TIM_BASE_PRE3    50

// AXI responses
`define TIM_RESP_OKAY    2'h0
`define TIM_RESP_SLVERR  2'h2

`endif

// File: hw/tim_pkg.sv
// Types for the timer input measurement channel
`default_nettype none
package tim_pkg;
  typedef enum logic [1:0] {
    TIM_DEB_ARMED,
    TIM_DEB_HOLD
  } tim_deb_state_type;
endpackage
`default_nettype wire

// File: verif/tim_input_meas_asserts.sv
// Concurrent checks on the register bus of the timer input channel
`default_nettype none
module tim_meas_chk (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic SYS_RST_IN,
  // Write channels
  input wire logic S_AXI_AWVALID_IN,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic [3:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_WVALID_IN,
  input wire logic S_AXI_WREADY_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [1:0] S_AXI_BRESP_OUT,
  // Read channels
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic [31:0] S_AXI_RDATA_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Handshake timing
  // ----------------------------------------
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  // Both write halves taken at one edge, the way the bench offers them
  logic wr_go;
  assign wr_go = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  chk_wr_answer: assert property (wr_go |-> ##1 !S_AXI_BVALID_OUT ##1 S_AXI_BVALID_OUT)
    else $error("write answer not two edges after acceptance");
  chk_wr_ready_drop: assert property (wr_go |=> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
    else $error("write readies stay high while a write is held");
  chk_status_ro: assert property (wr_go && S_AXI_AWADDR_IN == 4'hc |-> ##2 S_AXI_BRESP_OUT == 2'h2)
    else $error("status write not refused");
  chk_b_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
    S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write response dropped early");
  chk_rd_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT
    |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT) else $error("read answer late");
  chk_ar_blocked: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
    else $error("read address ready while read data pending");
  chk_r_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
    S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT)) else $error("read data not held");
  // Reset must leave the bus idle; not disabled by reset on purpose
  chk_rst_idle: assert property (@(posedge MCLK_IN) disable iff (1'h0) SYS_RST_IN |=>
    S_AXI_AWREADY_OUT && S_AXI_ARREADY_OUT && !S_AXI_BVALID_OUT && !S_AXI_RVALID_OUT)
    else $error("bus not idle");
  cover property (wr_go);
  cover property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN);
  cover property (S_AXI_BVALID_OUT && S_AXI_BRESP_OUT == 2'h2);
endmodule

bind tim_input_meas tim_meas_chk chk_u (
  .MCLK_IN, .SYS_RST_IN, .S_AXI_AWVALID_IN, .S_AXI_AWREADY_OUT, .S_AXI_AWADDR_IN,
  .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT, .S_AXI_BREADY_IN, .S_AXI_BRESP_OUT,
  .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .S_AXI_RDATA_OUT
);
`default_nettype wire

// File: verif/tim_pin_model.sv
// Behavioural signal source that drives the measured pin
`default_nettype none
module tim_pin_model (
  // Clock
  input wire logic clk_in,
  // Waveform control
  input wire logic run_in,
  input wire logic idle_lvl_in,
  input wire logic [15:0] hi_len_in,
  input wire logic [15:0] lo_len_in,
  // Pin
  output logic pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  initial begin
    pin_out = 1'h0;
    cnt = 16'h0001;
  end
  // phases kept short
  // Square wave while running, so the 16-bit phase counts never overflow
  always @(posedge clk_in) begin
    if (!run_in) begin
      pin_out <= idle_lvl_in;
      cnt <= 16'h0001;
    end else if (cnt >= (pin_out ? hi_len_in : lo_len_in)) begin
      pin_out <= ~pin_out;
      cnt <= 16'h0001;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb.sv
// Self-checking bench for the timer input measurement channel
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, run = 1'h0, lvl = 1'h0;
  logic aw_v = 1'h0, w_v = 1'h0, b_rdy = 1'h0, ar_v = 1'h0, r_rdy = 1'h0;
  logic [3:0] aw_a = 4'h0, ar_a = 4'h0;
  logic [15:0] hi = 16'h000a, lo = 16'h000a;
  logic [31:0] w_d = 32'h0, v, c0;
  logic [1:0] rsp;
  wire logic pin, awr, wrdy, bv, arr, rv;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd_d;
  int miscompares = 0;
  int samples_checked = 0;
  // ----------------------------------------
  // Clock, device and pin source
  // ----------------------------------------
  always #10 clk = ~clk;
  tim_input_meas dut_u (
    .MCLK_IN(clk), .SYS_RST_IN(rst), .MEAS_PIN_IN(pin),
    .S_AXI_AWVALID_IN(aw_v), .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(aw_a),
    .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(wrdy), .S_AXI_WDATA_IN(w_d), .S_AXI_WSTRB_IN(4'hf),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(b_rdy), .S_AXI_BRESP_OUT(br),
    .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ar_a),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(r_rdy), .S_AXI_RDATA_OUT(rd_d), .S_AXI_RRESP_OUT(rr)
  );
  tim_pin_model src_u (.clk_in(clk), .run_in(run), .idle_lvl_in(lvl), .hi_len_in(hi),
    .lo_len_in(lo), .pin_out(pin));
  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic stall();
    miscompares++;
    $display("BAD handshake expected done seen timeout");
    results();
  endtask
  // Response readies come late on purpose so the held answers get exercised
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic got;
    got = 1'h0;
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    for (int n = 0; n < 60 && !got; n++) begin
      @(posedge clk);
      if (aw_v && awr) aw_v <= 1'h0;
      if (w_v && wrdy) w_v <= 1'h0;
      if (n == 3) b_rdy <= 1'h1;
      if (bv && b_rdy) begin
        rsp = br;
        got = 1'h1;
      end
    end
    b_rdy <= 1'h0;
    if (!got) stall();
  endtask
  task automatic rd_reg(input logic [3:0] a);
    logic got;
    got = 1'h0;
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'h1;
    for (int n = 0; n < 60 && !got; n++) begin
      @(posedge clk);
      if (ar_v && arr) ar_v <= 1'h0;
      if (n == 3) r_rdy <= 1'h1;
      if (rv && r_rdy) begin
        v = rd_d;
        rsp = rr;
        got = 1'h1;
      end
    end
    r_rdy <= 1'h0;
    if (!got) stall();
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
    rd_reg(a);
    check(nm, v, e);
  endtask
  task automatic wave(input logic [15:0] h, input logic [15:0] l, input int cyc);
    @(posedge clk);
    hi <= h;
    lo <= l;
    run <= 1'h1;
    repeat (cyc) @(posedge clk);
  endtask
  // Each flip is one edge on the idle level, spaced well apart
  task automatic flip(input int k);
    repeat (k) begin
      @(posedge clk);
      lvl <= ~lvl;
      repeat (6) @(posedge clk);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rc(4'h0, 32'h2, "mode after reset");
    rc(4'h4, 32'h100, "clock config after reset");
    wr_reg(4'hc, 32'h1);
    check("status write response", 32'(rsp), 32'h2);
    // Unaligned read lands on the word holding it, the mode register
    rd_reg(4'h2);
    check("unaligned read response", 32'(rsp), 32'h0);
    check("unaligned read data", v, 32'h2);
    wave(16'h000a, 16'h001e, 200);
    rc(4'h8, 32'h14, "rising period");
    wave(16'h001e, 16'h0046, 300);
    rc(4'h8, 32'h32, "refreshed period");
    wr_reg(4'h0, 32'h3);
    wave(16'h0014, 16'h003c, 300);
    rc(4'h8, 32'h28, "falling period");
    wr_reg(4'h4, 32'h304);
    wr_reg(4'h0, 32'h2);
    wave(16'h003c, 16'h003c, 400);
    rc(4'h8, 32'h14, "divided tick period");
    wr_reg(4'h4, 32'h4);
    wave(16'h0200, 16'h0200, 4000);
    rc(4'h8, 32'h2, "divider zero period");
    wr_reg(4'h4, 32'h100);
    wr_reg(4'h0, 32'h4);
    wave(16'h0014, 16'h0028, 300);
    rc(4'h8, 32'h0014000a, "duty high and low");
    run <= 1'h0;
    wr_reg(4'h8, 32'h0);
    rc(4'h8, 32'hffff0000, "duty reset low");
    lvl <= 1'h1;
    repeat (10) @(posedge clk);
    wr_reg(4'h8, 32'h0);
    rc(4'h8, 32'h0000ffff, "duty reset high");
    flip(1);
    wr_reg(4'h0, 32'h5);
    wr_reg(4'h8, 32'h0);
    rc(4'h8, 32'h0, "counter cleared");
    flip(6);
    rc(4'h8, 32'h3, "edge count");
    // Read arrives at the very edge that commits the clearing write
    fork
      wr_reg(4'h8, 32'h0);
      begin
        repeat (1) @(posedge clk);
        rd_reg(4'h8);
      end
    join
    check("read beside clear", v, 32'h3);
    rc(4'h8, 32'h0, "count after clear");
    wr_reg(4'h0, 32'h6);
    // Only the hold window is exercised; a slow switch would re-arm between presses
    wr_reg(4'h8, 32'h105);
    rd_reg(4'h8);
    c0 = v;
    flip(1);
    rc(4'h8, c0 + 32'h1, "debounce rising edge");
    flip(4);
    rc(4'h8, c0 + 32'h1, "edges ignored in hold");
    rd_reg(4'hc);
    check("debounce holding", 32'(v[10]), 32'h1);
    check("debounce periods loaded", 32'(v[9:1]), 32'h6);
    @(posedge clk);
    rst <= 1'h1;
    lvl <= 1'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    wr_reg(4'h0, 32'h6);
    wr_reg(4'h8, 32'h0);
    rd_reg(4'h8);
    c0 = v;
    flip(1);
    rc(4'h8, c0, "rising edge not counted");
    flip(1);
    rc(4'h8, c0 + 32'h1, "falling edge counted");
    results();
  end
  // Cuts a hang short
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    $display("BAD run expected end seen timeout");
    results();
  end
endmodule
`default_nettype wire
